/* File: verilog/accel_filter_irq_format_ctrl.sv */
// Purpose: configuration registers for filter, interrupt pads, format
// Assumes: serial front end gives decoded byte reads and writes
// Notes:   sample path, filter arithmetic and engines live elsewhere
//
// Summary of operation
// RULE_01: Rate code gives sample rate and low-pass corner.
// RULE_02: Trim reload copies calibration then clears itself.
// RULE_03: Power-up copies calibration without host action.
// RULE_04: Filter mode 00/10 normal, 01 uses reference.
// RULE_05: Filtered-output bit sends filtered data to outputs.
// RULE_06: Per-engine bits feed filtered data to engines.
// RULE_07: Corner code picks divisor 8, 16, 32, 64.
// RULE_08: Polarity bit: zero active high, one low.
// RULE_09: Drive bit: zero push-pull, one open drain.
// RULE_10: Latched request held until source register read.
// RULE_11: Route field picks own, OR, ready, boot.
// RULE_12: Hold update freezes pair until both bytes read.
// RULE_13: Host should set hold update when reading slowly.
// RULE_14: Byte order bit picks which byte sits lower.
// RULE_15: Range field: 6 g, 12 g, 24 g.
// RULE_16: Self-check enable and sign drive stimulus.
// RULE_17: Wire-count bit picks four or three wires.
// RULE_18: All three control registers reset to zero.
// RULE_19: Reading clear address zeroes filter state; no clear pulse while highpass_use_ref is set.
// RULE_20: Reference used when filter routed and mode 01.
// RULE_21: Host avoids undefined mode and range codes.
`timescale 1ns/1ns
`default_nettype none
`include "accel_ctrl_defines.svh"
module accel_filter_irq_format_ctrl
  import accel_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic [1:0]  rate_code,
  input  wire logic [7:0]  reference,
  input  wire logic [47:0] sample_raw,
  input  wire logic [47:0] sample_hp,
  input  wire logic        sample_valid,
  input  wire logic        irq1_req,
  input  wire logic        irq2_req,
  input  wire logic        data_ready,
  output logic [2:0]       nv_index,
  input  wire logic [7:0]  nv_word,
  output logic [63:0]      trim_words,
  output logic [10:0]      sample_rate,
  output logic [9:0]       lowpass_corner,
  output logic [6:0]       highpass_divisor,
  output logic [10:0]      highpass_corner_x6,
  output logic             highpass_use_ref,
  output logic             highpass_clear,
  output logic [7:0]       highpass_reference,
  output logic             irq1_use_hp,
  output logic             irq2_use_hp,
  output logic             irq1_pending,
  output logic             irq2_pending,
  output logic [1:0]       range_select,
  output logic             auto_check_on,
  output logic             auto_check_polarity,
  output logic             wire_count_sel,
  output logic             pad1_out,
  output logic             pad1_oe,
  output logic             pad2_out,
  output logic             pad2_oe
);
  logic [7:0]  highpass_trim_ctrl;
  logic [7:0]  irq_pad_ctrl;
  logic [7:0]  output_format_ctrl;
  logic [47:0] out_pair;
  logic [2:0]  pair_half_read;
  logic        boot_busy;
  logic        boot_done;
  logic        wr_hp;
  logic        rd_hit;
  logic [2:0]  pair_idx;
  logic        is_out;
  logic [7:0]  next_rdata;
  logic [1:0]  highpass_mode;
  logic        filtered_out_sel;
  logic        any_route;
  logic        hold_pair_update;
  logic        byte_order;

  assign wr_hp  = ce && reg_wr && (reg_addr == `ADDR_HIGHPASS_TRIM_CTRL);
  assign rd_hit = ce && reg_rd;
  assign is_out = (reg_addr >= `ADDR_OUT_BASE) && (reg_addr <= `ADDR_OUT_LAST);
  assign pair_idx = 3'(reg_addr - `ADDR_OUT_BASE);

  // Filter/trim register; reload bit cleared when the copy ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highpass_trim_ctrl <= `CTRL_RESET; // see RULE_18
    end else if (ce) begin
      if (wr_hp) begin
        highpass_trim_ctrl <= reg_wdata;
      end else if (boot_done) begin
        highpass_trim_ctrl[`BIT_TRIM_RELOAD] <= 1'b0; // see RULE_02
      end
    end
  end

  // Interrupt pad and format registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_pad_ctrl       <= `CTRL_RESET; // see RULE_18
      output_format_ctrl <= `CTRL_RESET; // see RULE_18
    end else if (ce && reg_wr) begin
      if (reg_addr == `ADDR_IRQ_PAD_CTRL) begin
        irq_pad_ctrl <= reg_wdata;
      end
      if (reg_addr == `ADDR_OUTPUT_FORMAT_CTRL) begin
        output_format_ctrl <= reg_wdata;
      end
    end
  end

  // Calibration copy engine, also runs once from reset
  trim_loader u_trim (
    .clk        (clk),
    .rstn       (rstn),
    .ce         (ce),
    .start      (wr_hp && reg_wdata[`BIT_TRIM_RELOAD]), // see RULE_02
    .nv_index   (nv_index),
    .nv_word    (nv_word),
    .trim_words (trim_words),
    .busy       (boot_busy), // see RULE_03
    .done       (boot_done)
  );

  // Field decode
  assign highpass_mode    = highpass_trim_ctrl[6:5];
  assign filtered_out_sel = highpass_trim_ctrl[`BIT_FILTERED_OUT_SEL];
  assign irq2_use_hp = highpass_trim_ctrl[`BIT_HP_IRQ2_APPLY]; // see RULE_06
  assign irq1_use_hp = highpass_trim_ctrl[`BIT_HP_IRQ1_APPLY]; // see RULE_06
  assign any_route   = filtered_out_sel | irq1_use_hp | irq2_use_hp;
  assign hold_pair_update    = output_format_ctrl[`BIT_HOLD_PAIR_UPDATE];
  assign byte_order          = output_format_ctrl[`BIT_BYTE_ORDER];
  assign range_select        = output_format_ctrl[5:4]; // see RULE_15
  assign auto_check_polarity = output_format_ctrl[`BIT_AUTO_CHECK_POL];
  assign auto_check_on = output_format_ctrl[`BIT_AUTO_CHECK_ON]; // see RULE_16
  assign wire_count_sel = // see RULE_17
      output_format_ctrl[`BIT_WIRE_COUNT_SEL];
  assign highpass_reference  = reference;

  // Rate, corner and divisor lookups, registered as data outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_rate        <= `RATE_0;
      lowpass_corner     <= `LPF_0;
      highpass_divisor   <= `HP_DIV_0;
      highpass_corner_x6 <= 11'h000;
      highpass_use_ref   <= 1'b0;
    end else if (ce) begin
      unique case (rate_code) // see RULE_01
        2'b00: begin
          sample_rate    <= `RATE_0;
          lowpass_corner <= `LPF_0;
        end
        2'b01: begin
          sample_rate    <= `RATE_1;
          lowpass_corner <= `LPF_1;
        end
        2'b10: begin
          sample_rate    <= `RATE_2;
          lowpass_corner <= `LPF_2;
        end
        2'b11: begin
          sample_rate    <= `RATE_3;
          lowpass_corner <= `LPF_3;
        end
      endcase
      unique case (highpass_trim_ctrl[1:0]) // see RULE_07
        2'b00: highpass_divisor <= `HP_DIV_0;
        2'b01: highpass_divisor <= `HP_DIV_1;
        2'b10: highpass_divisor <= `HP_DIV_2;
        2'b11: highpass_divisor <= `HP_DIV_3;
      endcase
      // Divisor times six; corner is rate over this value
      highpass_corner_x6 <= {4'h0, highpass_divisor} *
          {7'h00, `HP_APPROX_FACTOR};
      // Codes 00 and 10 both mean normal; 11 left as normal
      highpass_use_ref <= any_route && // see RULE_04 RULE_20
          (highpass_mode_t'(highpass_mode) == hp_reference);
    end
  end

  // One-cycle clear pulse on a read of the dummy address while highpass_use_ref is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highpass_clear <= 1'b0;
    end else if (ce) begin
      highpass_clear <= rd_hit && (reg_addr == `ADDR_HIGHPASS_CLEAR) &&
          !highpass_use_ref; // see RULE_19, RULE_04
    end
  end

  // Latched requests; a new request wins over the read that clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq1_pending <= 1'b0;
      irq2_pending <= 1'b0;
    end else if (ce) begin
      if (!irq_pad_ctrl[`BIT_IRQ1_LATCH]) begin
        irq1_pending <= irq1_req;
      end else if (irq1_req) begin
        irq1_pending <= 1'b1; // see RULE_10
      end else if (rd_hit && reg_addr == `ADDR_IRQ1_SOURCE) begin
        irq1_pending <= 1'b0; // see RULE_10
      end
      if (!irq_pad_ctrl[`BIT_IRQ2_LATCH]) begin
        irq2_pending <= irq2_req;
      end else if (irq2_req) begin
        irq2_pending <= 1'b1; // see RULE_10
      end else if (rd_hit && reg_addr == `ADDR_IRQ2_SOURCE) begin
        irq2_pending <= 1'b0; // see RULE_10
      end
    end
  end

  // Output pairs; with hold update a pair waits for its second byte
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pair
      logic rd_lo;
      logic rd_hi;
      assign rd_lo = rd_hit && is_out && (pair_idx == 3'(2 * g));
      assign rd_hi = rd_hit && is_out && (pair_idx == 3'(2 * g + 1));
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          out_pair[g*16 +: 16] <= 16'h0000;
          pair_half_read[g]    <= 1'b0;
        end else if (ce) begin
          if (!hold_pair_update) begin
            pair_half_read[g] <= 1'b0;
          end else if (rd_lo || rd_hi) begin
            pair_half_read[g] <= !pair_half_read[g]; // see RULE_12
          end
          if (sample_valid && !(hold_pair_update &&
              (pair_half_read[g] || rd_lo || rd_hi))) begin
            out_pair[g*16 +: 16] <= filtered_out_sel ? // see RULE_05
                sample_hp[g*16 +: 16] : sample_raw[g*16 +: 16];
          end
        end
      end
    end
  endgenerate

  // Read data mux, registered
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == `ADDR_HIGHPASS_TRIM_CTRL) begin
      next_rdata = highpass_trim_ctrl;
    end else if (reg_addr == `ADDR_IRQ_PAD_CTRL) begin
      next_rdata = irq_pad_ctrl;
    end else if (reg_addr == `ADDR_OUTPUT_FORMAT_CTRL) begin
      next_rdata = output_format_ctrl;
    end else if (is_out) begin
      // Lower address holds low byte unless order bit set
      next_rdata = (pair_idx[0] ^ byte_order) ? // see RULE_14
          out_pair[pair_idx[2:1]*16 + 8 +: 8] :
          out_pair[pair_idx[2:1]*16 +: 8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (rd_hit) begin
      reg_rdata <= next_rdata;
    end
  end

  // Interrupt pads
  pad_driver u_pad1 (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .route        (irq_pad_ctrl[1:0]), // see RULE_11
    .polarity     (irq_pad_ctrl[`BIT_IRQ_POLARITY]), // see RULE_08
    .drive_type   (irq_pad_ctrl[`BIT_IRQ_DRIVE_TYPE]), // see RULE_09
    .own_req      (irq1_pending),
    .other_req    (irq2_pending),
    .data_ready   (data_ready),
    .boot_running (boot_busy),
    .pad_out      (pad1_out),
    .pad_oe       (pad1_oe)
  );

  pad_driver u_pad2 (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .route        (irq_pad_ctrl[4:3]), // see RULE_11
    .polarity     (irq_pad_ctrl[`BIT_IRQ_POLARITY]), // see RULE_08
    .drive_type   (irq_pad_ctrl[`BIT_IRQ_DRIVE_TYPE]), // see RULE_09
    .own_req      (irq2_pending),
    .other_req    (irq1_pending),
    .data_ready   (data_ready),
    .boot_running (boot_busy),
    .pad_out      (pad2_out),
    .pad_oe       (pad2_oe)
  );
endmodule
`default_nettype wire

/* File: inc/accel_ctrl_defines.svh */
// Purpose: constants for the accelerometer configuration register logic
// Assumes: 7-bit register address, 8-bit registers
// Notes:   definitions only
`ifndef ACCEL_CTRL_DEFINES_SVH
`define ACCEL_CTRL_DEFINES_SVH
`define ADDR_HIGHPASS_TRIM_CTRL 7'h21
`define ADDR_IRQ_PAD_CTRL       7'h22
`define ADDR_OUTPUT_FORMAT_CTRL 7'h23
`define ADDR_HIGHPASS_CLEAR     7'h25
`define ADDR_REFERENCE          7'h26
`define ADDR_OUT_BASE           7'h28
`define ADDR_OUT_LAST           7'h2D
`define ADDR_IRQ1_SOURCE        7'h31
`define ADDR_IRQ2_SOURCE        7'h35
`define CTRL_RESET              8'h00
// Trim reload bit and fields of the filter/trim register
`define BIT_TRIM_RELOAD         7
`define BIT_FILTERED_OUT_SEL    4
`define BIT_HP_IRQ2_APPLY       3
`define BIT_HP_IRQ1_APPLY       2
// Interrupt pad register fields
`define BIT_IRQ_POLARITY        7
`define BIT_IRQ_DRIVE_TYPE      6
`define BIT_IRQ2_LATCH          5
`define BIT_IRQ1_LATCH          2
// Format register fields
`define BIT_HOLD_PAIR_UPDATE    7
`define BIT_BYTE_ORDER          6
`define BIT_AUTO_CHECK_POL      2
`define BIT_AUTO_CHECK_ON       1
`define BIT_WIRE_COUNT_SEL      0
// Number of trim words, index of the last trim word
`define TRIM_WORDS              4'h8
`define TRIM_LAST               3'h7
// High-pass divisors for corner codes 00..11
`define HP_DIV_0                7'h08
`define HP_DIV_1                7'h10
`define HP_DIV_2                7'h20
`define HP_DIV_3                7'h40
`define HP_APPROX_FACTOR        4'h6
// Rates in Hz, low-pass corners in Hz
`define RATE_0                  11'h032
`define RATE_1                  11'h064
`define RATE_2                  11'h190
`define RATE_3                  11'h3E8
`define LPF_0                   10'h025
`define LPF_1                   10'h04A
`define LPF_2                   10'h124
`define LPF_3                   10'h30C
`endif

/* File: inc/accel_ctrl_pkg.sv */
// Purpose: shared types of the configuration register logic
// Assumes: nothing
// Notes:   codes follow the register field encodings
package accel_ctrl_pkg;
  typedef enum logic [1:0] {
    hp_normal_a = 2'b00,
    hp_reference = 2'b01,
    hp_normal_b = 2'b10,
    hp_undefined = 2'b11
  } highpass_mode_t;
  typedef enum logic [1:0] {
    route_own = 2'b00,
    route_either = 2'b01,
    route_data_ready = 2'b10,
    route_boot = 2'b11
  } pad_route_t;
  typedef enum logic [1:0] {
    range_6g = 2'b00,
    range_12g = 2'b01,
    range_undefined = 2'b10,
    range_24g = 2'b11
  } range_select_t;
  typedef enum logic [1:0] {
    trim_idle = 2'b00,
    trim_copy = 2'b01,
    trim_done = 2'b10
  } trim_state_t;
endpackage

/* File: verilog/trim_loader.sv */
// Purpose: copies nonvolatile calibration words into trim registers
// Assumes: nonvolatile word readable one cycle after its index is shown
// Notes:   starts by itself after reset and again on request
`timescale 1ns/1ns
`default_nettype none
`include "accel_ctrl_defines.svh"
module trim_loader
  import accel_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       start,
  output logic [2:0]      nv_index,
  input  wire logic [7:0] nv_word,
  output logic [63:0]     trim_words,
  output logic            busy,
  output logic            done
);
  trim_state_t state;
  logic [3:0]  count;
  logic [2:0]  prev_index;

  // Begins in the copy state so power-up loads trims unasked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= trim_copy;
      count <= 4'h0;
    end else if (ce) begin
      unique case (state)
        trim_idle: begin
          count <= 4'h0;
          if (start) begin
            state <= trim_copy;
          end
        end
        trim_copy: begin
          count <= count + 4'h1;
          if (count == `TRIM_WORDS) begin
            state <= trim_done;
          end
        end
        trim_done: begin
          count <= 4'h0;
          state <= start ? trim_copy : trim_idle;
        end
        default: begin
          state <= trim_idle;
        end
      endcase
    end
  end

  assign nv_index = count[2:0];
  assign busy     = (state == trim_copy);
  assign done     = (state == trim_done);

  // Word shown last cycle arrives now, store it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_index <= 3'h0;
      trim_words <= 64'h0;
    end else if (ce) begin
      prev_index <= count[2:0];
      if (busy && count != 4'h0) begin
        trim_words[prev_index*8 +: 8] <= nv_word;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/pad_driver.sv */
// Purpose: one interrupt pad: route select, polarity, drive type
// Assumes: request inputs are active high levels
// Notes:   open drain only ever pulls the pad low
`timescale 1ns/1ns
`default_nettype none
`include "accel_ctrl_defines.svh"
module pad_driver
  import accel_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic [1:0] route,
  input  wire logic       polarity,
  input  wire logic       drive_type,
  input  wire logic       own_req,
  input  wire logic       other_req,
  input  wire logic       data_ready,
  input  wire logic       boot_running,
  output logic            pad_out,
  output logic            pad_oe
);
  logic sel;
  logic level;

  // Source chosen by the route field
  always_comb begin
    unique case (pad_route_t'(route))
      route_own:        sel = own_req;
      route_either:     sel = own_req | other_req;
      route_data_ready: sel = data_ready;
      route_boot:       sel = boot_running;
    endcase
  end

  assign level = sel ^ polarity;

  // Registered so the pad never glitches between routes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b1;
    end else if (ce) begin
      pad_out <= level;
      // Open drain: drive only the low level, float otherwise
      pad_oe  <= drive_type ? !level : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/accel_ctrl_checker.sv */
// Purpose: port checks of the configuration register logic
// Assumes: shadow copies follow host writes taken with ce high
// Notes:   reload bit self-clears; fields compared
`timescale 1ns/1ns
`default_nettype none
module accel_ctrl_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  rate_code,
  input wire logic        irq1_req,
  input wire logic        irq1_pending,
  input wire logic [10:0] sample_rate,
  input wire logic [9:0]  lowpass_corner,
  input wire logic [6:0]  highpass_divisor,
  input wire logic [10:0] highpass_corner_x6,
  input wire logic        highpass_use_ref,
  input wire logic        highpass_clear,
  input wire logic        irq1_use_hp,
  input wire logic [1:0]  range_select,
  input wire logic        auto_check_on,
  input wire logic        wire_count_sel,
  input wire logic        pad1_out,
  input wire logic        pad1_oe
);
  localparam logic [10:0] RATES [4] = '{11'h032, 11'h064, 11'h190, 11'h3E8};
  localparam logic [9:0]  CORNERS [4] = '{10'h025, 10'h04A, 10'h124, 10'h30C};
  logic [7:0] sh21, sh22, sh23;
  logic       live;
  // Shadow copies of what the host wrote
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh21 <= 8'h00;
      sh22 <= 8'h00;
      sh23 <= 8'h00;
    end else if (ce && reg_wr) begin
      if (reg_addr == 7'h21) sh21 <= reg_wdata;
      if (reg_addr == 7'h22) sh22 <= reg_wdata;
      if (reg_addr == 7'h23) sh23 <= reg_wdata;
    end
  end
  // Last edge live, so $past never sees reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) live <= 1'b0;
    else live <= ce;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rate_decode: assert property (
    live |-> sample_rate == RATES[$past(rate_code)]
      && lowpass_corner == CORNERS[$past(rate_code)])
    else $error("rate decode wrong");
  chk_corner_divisor: assert property (
    live |-> highpass_divisor == (7'h08 << $past(sh21[1:0])))
    else $error("divisor wrong");
  chk_corner_times6: assert property (
    live |-> highpass_corner_x6 == {4'h0, $past(highpass_divisor)} * 11'h006)
    else $error("corner product wrong");
  chk_ref_select: assert property (
    live |-> highpass_use_ref == ($past(sh21[6:5]) == 2'b01
      && $past(sh21[4:2]) != 3'b000))
    else $error("reference use wrong");
  chk_clear_pulse: assert property (
    ce && reg_rd && reg_addr == 7'h25 && sh21[6:5] != 2'b01 |=> highpass_clear)
    else $error("filter clear missing");
  chk_clear_cause: assert property (
    highpass_clear |-> $past(reg_rd && reg_addr == 7'h25))
    else $error("filter clear without read");
  chk_field_copy: assert property (
    irq1_use_hp == sh21[2] && range_select == sh23[5:4]
      && auto_check_on == sh23[1] && wire_count_sel == sh23[0])
    else $error("field output wrong");
  chk_read_back: assert property (
    live && $past(reg_rd) && $past(reg_addr[6:1]) == 6'h11 |->
      reg_rdata == ($past(reg_addr[0]) ? $past(sh23) : $past(sh22)))
    else $error("read data wrong");
  chk_pend_follow: assert property (
    live && !$past(sh22[2]) |-> irq1_pending == $past(irq1_req))
    else $error("pending does not follow");
  chk_pend_hold: assert property (
    live && $past(sh22[2] && irq1_pending)
      && !$past(reg_rd && reg_addr == 7'h31) |-> irq1_pending)
    else $error("latched request lost");
  chk_pad_push: assert property (
    live && $past(sh22[1:0]) == 2'b00 && !$past(sh22[6]) |->
      pad1_oe && pad1_out == $past(irq1_pending ^ sh22[7]))
    else $error("pad level wrong");
  chk_pad_drain: assert property (
    live && $past(sh22[1:0]) == 2'b00 && $past(sh22[6]) |->
      pad1_oe == !$past(irq1_pending ^ sh22[7]))
    else $error("open drain enable wrong");
endmodule
`default_nettype wire

/* File: tb/host_bus_model.sv */
// Purpose: host side of the register bus, one byte per strobe
// Assumes: read data valid the cycle after the strobe is taken
// Notes:   address and data scrambled once released
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input  wire logic       clk,
  output logic [6:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released lines never keep the old value
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/accel_filter_irq_format_ctrl_tb.sv */
// Purpose: self-checking bench of the configuration register logic
// Assumes: calibration store answers a cycle late
// Notes:   host bus traffic goes through the host model
`timescale 1ns/1ns
`default_nettype none
module accel_filter_irq_format_ctrl_tb;
  logic        clk, rstn, ce, reg_wr, reg_rd, sample_valid, irq1_req;
  logic        irq2_req, data_ready, highpass_use_ref, highpass_clear;
  logic        irq1_use_hp, irq2_use_hp, irq1_pending, irq2_pending;
  logic        auto_check_on, auto_check_polarity, wire_count_sel;
  logic        pad1_out, pad1_oe, pad2_out, pad2_oe;
  logic [1:0]  rate_code, range_select;
  logic [2:0]  nv_index;
  logic [6:0]  reg_addr, highpass_divisor;
  logic [7:0]  reg_rdata, reg_wdata, reference, nv_word, d, v, nv_seed;
  logic [7:0]  highpass_reference;
  logic [9:0]  lowpass_corner;
  logic [10:0] sample_rate, highpass_corner_x6;
  logic [47:0] sample_raw, sample_hp, sa, sb;
  logic [63:0] trim_words;
  int          errors, comparisons, i;
  int          model[3];
  int          rates[4] = '{50, 100, 400, 1000};
  int          lpf[4] = '{37, 74, 292, 780};
  accel_filter_irq_format_ctrl i_accel_filter_irq_format_ctrl (.*);
  host_bus_model i_host_bus_model (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Calibration store answers a cycle late
  always @(posedge clk) nv_word <= nv_seed + {5'h00, nv_index};
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(int k, logic [7:0] x);
    i_host_bus_model.wr(7'h21 + k[6:0], x);
    model[k] = x;
  endtask
  task automatic rchk(int k);
    i_host_bus_model.rd(7'h21 + k[6:0], d);
    check("ctrl reg", d, model[k]);
  endtask
  task automatic rout(logic [6:0] a, logic [7:0] exp);
    i_host_bus_model.rd(a, d);
    check("out byte", d, exp);
  endtask
  task automatic put(logic [47:0] raw, logic [47:0] hp);
    @(posedge clk);
    sample_raw <= raw;
    sample_hp <= hp;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    tick(2);
  endtask
  function automatic logic [63:0] trim_exp();
    for (int k = 0; k < 8; k++) trim_exp[8*k+:8] = nv_seed + k[7:0];
  endfunction
  // Hang guard, well past the test length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    {rate_code, reference, sample_raw, sample_hp} = '0;
    {sample_valid, irq1_req, irq2_req, data_ready} = 4'h0;
    model = '{0, 0, 0};
    nv_seed = 8'($urandom(32'h639E));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    tick(14);
    check("power-up trim", trim_words, trim_exp());
    for (int k = 0; k < 3; k++) rchk(k);
    rout(7'h2E, 8'h00);
    repeat (24) begin
      i = $urandom_range(2);
      v = 8'($urandom);
      if (i == 0) v[7] = 1'b0;
      if (i == 0 && v[6:5] == 2'b11) v[6] = 1'b0;
      if (i == 2 && v[5:4] == 2'b10) v[5] = 1'b0;
      wreg(i, v);
      rchk(i);
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      rate_code <= r[1:0];
      reference <= 8'($urandom);
      tick(2);
      check("rate", sample_rate, rates[r]);
      check("low-pass", lowpass_corner, lpf[r]);
      check("reference", highpass_reference, reference);
      wreg(0, 8'(r));
      tick(2);
      check("divisor", highpass_divisor, 8 << r);
      check("corner x6", highpass_corner_x6, 48 << r);
    end
    // Reload with pad 2 showing boot running
    wreg(1, 8'h18);
    nv_seed = nv_seed + 8'h3C;
    wreg(0, 8'h80);
    i_host_bus_model.rd(7'h21, d);
    check("reload bit", d[7], 1'b1);
    check("boot pad", pad2_out, 1'b1);
    tick(14);
    model[0] = 0;
    rchk(0);
    check("reloaded trim", trim_words, trim_exp());
    for (int m = 0; m < 3; m++) begin
      wreg(0, {1'b0, m[1:0], 5'h10});
      i_host_bus_model.rd(7'h25, d);
      check("clear", highpass_clear, m != 1);
      check("use ref", highpass_use_ref, m == 1);
      tick(1);
      check("clear end", highpass_clear, 1'b0);
    end
    wreg(1, 8'h04);
    @(posedge clk) irq1_req <= 1'b1;
    @(posedge clk) irq1_req <= 1'b0;
    tick(3);
    check("latched", irq1_pending, 1'b1);
    check("pad high", pad1_out, 1'b1);
    i_host_bus_model.rd(7'h31, d);
    tick(1);
    check("source read", irq1_pending, 1'b0);
    wreg(1, 8'hC0);
    for (int l = 1; l >= 0; l--) begin
      @(posedge clk) irq1_req <= l[0];
      tick(3);
      check("drain oe", pad1_oe, l[0]);
    end
    for (int r = 0; r < 3; r++) begin
      wreg(1, {3'h0, r[1:0], 3'h0});
      @(posedge clk);
      irq2_req <= (r == 0);
      irq1_req <= (r == 1);
      data_ready <= (r == 2);
      tick(3);
      check("route on", pad2_out, 1'b1);
      @(posedge clk) {irq1_req, irq2_req, data_ready} <= 3'h0;
      tick(3);
      check("route off", pad2_out, 1'b0);
    end
    for (int f = 0; f < 4; f++) begin
      wreg(0, {3'h0, f[0], 4'h0});
      wreg(2, {1'b0, f[1], 6'h00});
      sa = 48'({$urandom, $urandom});
      sb = 48'({$urandom, $urandom});
      put(sa, sb);
      if (f[0]) sa = sb;
      for (int a = 0; a < 6; a++)
        rout(7'h28 + a[6:0], (a[0] ^ f[1]) ?
            sa[16*(a/2)+8+:8] : sa[16*(a/2)+:8]);
    end
    // Slow host, so pairs are held while read
    wreg(2, 8'h80);
    put(sb, sb);
    rout(7'h28, sb[7:0]);
    sa = ~sb;
    put(sa, sa);
    rout(7'h29, sb[15:8]);
    put(sa, sa);
    rout(7'h28, sa[7:0]);
    rout(7'h29, sa[15:8]);
    print_verdict();
  end
endmodule
bind accel_filter_irq_format_ctrl accel_ctrl_checker i_chk (.*);
`default_nettype wire
